// ---- test/spi_master_slave_port_tb.sv ----
// Self-checking bench for the serial peripheral port
`timescale 1ns/100ps
module spi_master_slave_port_tb;
  import spi_port_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic port_enable_i, select_ignore_i, bit_order_i, clock_polarity_i;
  logic clock_phase_i, chain_mode_enable_i, irq_enable_i, master_role_wr_i;
  logic master_role_val_i, data_wr_i, done_clear_i, collision_clear_i;
  logic mode_fault_clear_i, uart_baud_gen_overflow_i, timer_zero_overflow_i;
  logic slave_select_n_i, master_role_bit_o, transfer_done_flag_o;
  logic write_collision_flag_o, holding_full_flag_o, engine_busy_flag_o;
  logic mode_fault_flag_o, port_irq_o, serial_clock_pin_o, mosi_o, miso_o;
  logic serial_clock_pin_oe_o, mosi_oe_o, miso_oe_o, peer_cs_n, peer_miso;
  logic sclk_q;
  logic ext_sclk = 1'b0;
  logic ext_mosi = 1'b0;
  logic [2:0] rate_select_i;
  logic [BYTE_BITS-1:0] data_wr_byte_i, rx_data_o, peer_tx, peer_rx;
  wire logic serial_clock_pin_i, mosi_i, miso_i;
  int fails = 0;
  int total_checks = 0;
  int n;
  int per [8] = '{4, 8, 16, 32, 64, 2, 6, 6};
  assign serial_clock_pin_i = serial_clock_pin_oe_o ? serial_clock_pin_o :
    ext_sclk;
  assign mosi_i = mosi_oe_o ? mosi_o : ext_mosi;
  assign miso_i = miso_oe_o ? miso_o : peer_miso;
  always #12.5 clk_i = ~clk_i;
  always_ff @(posedge clk_i) sclk_q <= serial_clock_pin_o;
  spi_master_slave_port spi_master_slave_port_inst (.*);
  spi_peer_model spi_peer_model_inst (.sclk_i(serial_clock_pin_i),
    .cs_n_i(peer_cs_n), .mosi_i(mosi_i), .tx_i(peer_tx),
    .miso_o(peer_miso), .rx_o(peer_rx));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected value at %0t: %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk_i);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] b);
    data_wr_byte_i = b;
    pulse(data_wr_i);
  endtask
  // Bounded wait, so a stuck engine cannot hang the run
  task automatic wait_done();
    n = 0;
    while (transfer_done_flag_o !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    check(transfer_done_flag_o, 1'b1);
    pulse(done_clear_i);
  endtask
  task automatic rise();
    n = 0;
    do begin
      tick();
      n++;
    end while (!(serial_clock_pin_o && !sclk_q) && n < 500);
  endtask
  // External master, mode 3 only; halves of 4 clocks cover the sync delay
  task automatic xfer(input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] s;
    s = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      ext_sclk = 1'b0;
      ext_mosi = m[b];
      tick(4);
      ext_sclk = 1'b1;
      s = {s[6:0], miso_i};
      tick(4);
    end
    check(s, exp);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {port_enable_i, select_ignore_i, bit_order_i, clock_polarity_i} = '0;
    {clock_phase_i, chain_mode_enable_i, master_role_wr_i, data_wr_i} = '0;
    {done_clear_i, collision_clear_i, mode_fault_clear_i} = '0;
    {uart_baud_gen_overflow_i, timer_zero_overflow_i, irq_enable_i} = '1;
    {slave_select_n_i, peer_cs_n, master_role_val_i} = '1;
    rate_select_i = 3'h1;
    data_wr_byte_i = 8'h00;
    peer_tx = 8'h00;
    tick(8);
    rst_n_i = 1'b1;
    port_enable_i = 1'b1;
    pulse(master_role_wr_i);
    // Byte exchange in both bit orders
    for (int i = 0; i < 2; i++) begin
      bit_order_i = i[0];
      peer_tx = i ? 8'hC1 : 8'h3C;
      peer_cs_n = 1'b0;
      tick();
      wr(i ? 8'h1E : 8'hA5);
      wait_done();
      peer_cs_n = 1'b1;
      tick();
      check(rx_data_o, i ? 8'h83 : 8'h3C);
      check(peer_rx, i ? 8'h78 : 8'hA5);
    end
    // Back to back writes: second one meets a full holding buffer
    data_wr_byte_i = 8'h11;
    data_wr_i = 1'b1;
    tick();
    data_wr_byte_i = 8'h22;
    tick();
    data_wr_i = 1'b0;
    check(write_collision_flag_o, 1'b1);
    tick();
    wr(8'h33);
    check(holding_full_flag_o, 1'b1);
    check(engine_busy_flag_o, 1'b1);
    tick(20);
    check(write_collision_flag_o, 1'b1);
    pulse(collision_clear_i);
    check(write_collision_flag_o, 1'b0);
    wait_done();
    wait_done();
    tick(2);
    check(engine_busy_flag_o, 1'b0);
    // Serial clock period for every rate code
    for (int c = 0; c < 8; c++) begin
      rate_select_i = c[2:0];
      wr(8'h5A);
      rise();
      rise();
      check(8'(n), 8'(per[c]));
      wait_done();
    end
    // Another master selects this one
    slave_select_n_i = 1'b0;
    tick(6);
    check(master_role_bit_o, 1'b0);
    check(serial_clock_pin_oe_o, 1'b0);
    check(transfer_done_flag_o, 1'b1);
    check(port_irq_o, 1'b1);
    slave_select_n_i = 1'b1;
    pulse(done_clear_i);
    pulse(mode_fault_clear_i);
    tick(4);
    check(master_role_bit_o, 1'b0);
    check(port_irq_o, 1'b0);
    // Forced slave now; external master in mode 3, select held low
    clock_polarity_i = 1'b1;
    clock_phase_i = 1'b1;
    bit_order_i = 1'b0;
    ext_sclk = 1'b1;
    wr(8'hD2);
    tick();
    wr(8'h4B);
    tick(4);
    check(holding_full_flag_o, 1'b1);
    slave_select_n_i = 1'b0;
    tick(4);
    check(miso_oe_o, 1'b1);
    xfer(8'h96, 8'hD2);
    check(rx_data_o, 8'h96);
    xfer(8'h69, 8'h4B);
    check(rx_data_o, 8'h69);
    check(engine_busy_flag_o, 1'b0);
    // Chain enabled only once slave mode is set
    chain_mode_enable_i = 1'b1;
    wr(8'hE7);
    tick(2);
    xfer(8'h5C, 8'hE7);
    xfer(8'h3A, 8'h5C);
    slave_select_n_i = 1'b1;
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
endmodule

// ---- test/spi_peer_model.sv ----
// Far side slave device: clock mode 0, most significant bit first
`timescale 1ns/100ps
module spi_peer_model (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic [7:0] tx_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  logic [7:0] sh_q;
  initial begin
    miso_o = 1'b0;
    rx_o = 8'h00;
    sh_q = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////
  // Load on select, first bit ready before the leading edge
  always @(negedge cs_n_i) begin
    sh_q = tx_i;
    miso_o = tx_i[7];
  end
  // Released line: no stale level left behind
  always @(posedge cs_n_i) miso_o = ~miso_o;
  always @(posedge sclk_i) if (!cs_n_i) rx_o = {rx_o[6:0], mosi_i};
  always @(negedge sclk_i) if (!cs_n_i) begin
    sh_q = {sh_q[6:0], 1'b0};
    miso_o = sh_q[7];
  end
endmodule

// ---- test/spi_port_properties.sv ----
// Concurrent checks on the serial port engine, seen from its ports
`timescale 1ns/100ps
module spi_port_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic port_enable_i,
  input wire logic select_ignore_i,
  input wire logic clock_polarity_i,
  input wire logic irq_enable_i,
  input wire logic master_role_wr_i,
  input wire logic master_role_bit_o,
  input wire logic data_wr_i,
  input wire logic done_clear_i,
  input wire logic collision_clear_i,
  input wire logic transfer_done_flag_o,
  input wire logic write_collision_flag_o,
  input wire logic holding_full_flag_o,
  input wire logic engine_busy_flag_o,
  input wire logic mode_fault_flag_o,
  input wire logic port_irq_o,
  input wire logic [7:0] rx_data_o,
  input wire logic slave_select_n_i,
  input wire logic serial_clock_pin_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////
  hold_set_a:
  assert property (data_wr_i && !holding_full_flag_o |=> holding_full_flag_o)
    else $error("holding flag not set by write");
  collision_set_a:
  assert property (data_wr_i && holding_full_flag_o |=> write_collision_flag_o)
    else $error("collision flag not set");
  collision_sticky_a:
  assert property (write_collision_flag_o && !collision_clear_i
    |=> write_collision_flag_o) else $error("collision flag lost");
  done_sticky_a:
  assert property (transfer_done_flag_o && !done_clear_i
    |=> transfer_done_flag_o) else $error("done flag lost");
  // Select passes two sync stages before the role drops
  fault_role_a:
  assert property (port_enable_i && !select_ignore_i && master_role_bit_o &&
    !slave_select_n_i |-> ##[1:4] !master_role_bit_o)
    else $error("master role kept under select");
  slave_stays_a:
  assert property (!master_role_bit_o && !master_role_wr_i
    |=> !master_role_bit_o) else $error("master role came back");
  irq_gate_a:
  assert property (port_irq_o == (irq_enable_i &&
    (transfer_done_flag_o || mode_fault_flag_o)))
    else $error("interrupt output wrong");
  busy_held_a:
  assert property (holding_full_flag_o |-> engine_busy_flag_o)
    else $error("busy low with byte held");
  start_clock_a:
  assert property (master_role_bit_o && port_enable_i && data_wr_i &&
    !engine_busy_flag_o |-> ##[1:200] serial_clock_pin_o != clock_polarity_i)
    else $error("write did not start clock");
  rx_hold_a:
  assert property (!$stable(rx_data_o) |-> transfer_done_flag_o)
    else $error("receive data changed mid byte");
  cover property (!master_role_bit_o && $rose(transfer_done_flag_o));
  cover property (write_collision_flag_o);
  cover property (mode_fault_flag_o);
  cover property ($rose(transfer_done_flag_o));
endmodule
bind spi_master_slave_port spi_port_properties spi_port_properties_inst (.*);

// ---- verilog/rate_if.sv ----
// Signals between the port engine and its clock rate generator
`timescale 1ns/100ps
interface rate_if;
  logic run;
  logic [2:0] sel;
  logic uart_ovf;
  logic timer_ovf;
  logic half_tick;
  modport gen (input run, input sel, input uart_ovf, input timer_ovf,
               output half_tick);
  modport eng (output run, output sel, output uart_ovf, output timer_ovf,
               input half_tick);
endinterface

// ---- verilog/spi_master_slave_port.sv ----
// Serial peripheral port engine: master and slave roles
`timescale 1ns/100ps
module spi_master_slave_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic port_enable_i,
  input wire logic select_ignore_i,
  input wire logic bit_order_i,
  input wire logic clock_polarity_i,
  input wire logic clock_phase_i,
  input wire logic [2:0] rate_select_i,
  input wire logic chain_mode_enable_i,
  input wire logic irq_enable_i,
  input wire logic master_role_wr_i,
  input wire logic master_role_val_i,
  output logic master_role_bit_o,
  // Shift data register
  input wire logic data_wr_i,
  input wire logic [spi_port_pkg::BYTE_BITS-1:0] data_wr_byte_i,
  output logic [spi_port_pkg::BYTE_BITS-1:0] rx_data_o,
  // Status
  input wire logic done_clear_i,
  input wire logic collision_clear_i,
  input wire logic mode_fault_clear_i,
  output logic transfer_done_flag_o,
  output logic write_collision_flag_o,
  output logic holding_full_flag_o,
  output logic engine_busy_flag_o,
  output logic mode_fault_flag_o,
  output logic port_irq_o,
  // Overflow pulses from other timers, same clock
  input wire logic uart_baud_gen_overflow_i,
  input wire logic timer_zero_overflow_i,
  // Pins
  input wire logic slave_select_n_i,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o
);
  import spi_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: {select, clock, mosi, miso}

  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic ss_n_s;
  logic sclk_s;
  logic mosi_s;
  logic miso_s;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= {slave_select_n_i, serial_clock_pin_i, mosi_i, miso_i};
      sync2_q <= sync1_q;
    end
  end

  assign ss_n_s = sync2_q[3];
  assign sclk_s = sync2_q[2];
  assign mosi_s = sync2_q[1];
  assign miso_s = sync2_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // State

  master_state_type state_q;
  master_state_type state_d;
  logic master_q;
  logic sclk_q;
  logic sclk_prev_q;
  logic [2:0] cnt_q;
  logic first_q;
  logic active_q;
  logic [7:0] hold_q;
  logic hold_full_q;
  logic [7:0] osr_q;
  logic osr_full_q;
  logic [7:0] rx_sh_q;
  logic [7:0] rx_data_q;
  logic done_q;
  logic coll_q;
  logic fault_q;

  ////////////////////////////////////////////////////////////////////////////
  // Role selection

  logic mode_fault;
  logic is_master;
  logic slave_sel;
  logic slave_on;

  assign mode_fault = port_enable_i && !select_ignore_i && master_q &&
                      !ss_n_s;
  assign is_master = port_enable_i && master_q;
  assign slave_sel = select_ignore_i || !ss_n_s;
  assign slave_on = port_enable_i && !master_q && slave_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Rate generator

  rate_if rate ();

  assign rate.run = state_q != M_IDLE;
  assign rate.sel = rate_select_i;
  assign rate.uart_ovf = uart_baud_gen_overflow_i;
  assign rate.timer_ovf = timer_zero_overflow_i;

  spi_rate_gen u_rate (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .rate(rate.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge events of both roles

  logic m_edge;
  logic m_lead;
  logic m_trail;
  logic s_edge;
  logic s_lead;
  logic s_trail;
  logic lead_ev;
  logic trail_ev;
  logic sample_ev;
  logic change_ev;
  logic done_ev;
  logic in_bit;

  assign m_edge = state_q == M_SHIFT && rate.half_tick;
  assign m_lead = m_edge && (sclk_q == clock_polarity_i);
  assign m_trail = m_edge && (sclk_q != clock_polarity_i);
  // Edge detect reads only the second synchroniser stage
  assign s_edge = slave_on && (sclk_s != sclk_prev_q);
  assign s_lead = s_edge && (sclk_prev_q == clock_polarity_i);
  assign s_trail = s_edge && (sclk_prev_q != clock_polarity_i);

  assign lead_ev = is_master ? m_lead : s_lead;
  assign trail_ev = is_master ? m_trail : s_trail;
  assign sample_ev = clock_phase_i ? trail_ev : lead_ev;
  assign change_ev = clock_phase_i ? (lead_ev && !first_q) : trail_ev;
  // Byte ends on the eighth trailing edge in every mode
  assign done_ev = trail_ev && cnt_q == LAST_BIT;
  assign in_bit = is_master ? miso_s : mosi_s;

  ////////////////////////////////////////////////////////////////////////////
  // Bit position and receive assembly

  logic [2:0] pos;
  logic [7:0] mask;
  logic [7:0] rx_new;
  logic out_bit;

  assign pos = bit_order_i ? cnt_q : LAST_BIT - cnt_q;
  assign mask = 8'h01 << pos;
  assign rx_new = !sample_ev ? rx_sh_q :
                  in_bit ? (rx_sh_q | mask) : (rx_sh_q & ~mask);
  assign out_bit = osr_q[pos];

  ////////////////////////////////////////////////////////////////////////////
  // Master sequencer

  logic start_master;

  assign start_master = is_master && osr_full_q && !mode_fault;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      M_IDLE: begin
        if (start_master) begin
          state_d = M_SETUP;
        end
      end
      M_SETUP: begin
        // Half a bit here, then half a bit in M_SHIFT: a full bit of setup before the first clock edge
        if (rate.half_tick) begin
          state_d = M_SHIFT;
        end
      end
      M_SHIFT: begin
        if (done_ev) begin
          state_d = M_IDLE;
        end
      end
    endcase
    if (mode_fault || !is_master) begin
      state_d = M_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= M_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Serial clock toggles on each half tick while shifting
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
    end else if (state_q != M_SHIFT) begin
      sclk_q <= clock_polarity_i;
    end else if (m_edge) begin
      sclk_q <= !sclk_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter, shared by both roles

  logic restart;

  // Slave phase 0 frames each byte with the select line
  assign restart = is_master ? (state_q == M_IDLE) : !slave_on;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 3'h0;
      first_q <= 1'b1;
      active_q <= 1'b0;
      sclk_prev_q <= 1'b1;
      rx_sh_q <= DATA_RESET;
    end else begin
      sclk_prev_q <= sclk_s;
      rx_sh_q <= rx_new;
      if (restart || done_ev) begin
        // Select may stay low in phase 1; count restarts per byte
        cnt_q <= 3'h0;
        first_q <= 1'b1;
        active_q <= 1'b0;
      end else begin
        if (lead_ev) begin
          first_q <= 1'b0;
          active_q <= 1'b1;
        end
        if (change_ev) begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding buffer and output shifter

  logic wr_ok;
  logic wr_coll;
  logic move;
  logic chain_reload;

  assign wr_ok = data_wr_i && !hold_full_q;
  assign wr_coll = data_wr_i && hold_full_q;
  assign move = hold_full_q && !osr_full_q;
  assign chain_reload = done_ev && !is_master && chain_mode_enable_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      hold_q <= DATA_RESET;
      hold_full_q <= 1'b0;
      osr_q <= DATA_RESET;
      osr_full_q <= 1'b0;
    end else begin
      if (wr_ok) begin
        hold_q <= data_wr_byte_i;
        hold_full_q <= 1'b1;
      end else if (move) begin
        hold_full_q <= 1'b0;
      end
      if (chain_reload) begin
        // Copy of the byte just received goes out next group
        osr_q <= rx_new;
        osr_full_q <= 1'b1;
      end else if (done_ev) begin
        osr_full_q <= 1'b0;
      end else if (move) begin
        osr_q <= hold_q;
        osr_full_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer and master role bit

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_data_q <= DATA_RESET;
      master_q <= MASTER_RESET;
    end else begin
      if (done_ev) begin
        rx_data_q <= rx_new;
      end
      if (mode_fault) begin
        master_q <= 1'b0;
      end else if (master_role_wr_i) begin
        master_q <= master_role_val_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags; a setting event beats a same-cycle clear

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
      coll_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      done_q <= done_ev || mode_fault || (done_q && !done_clear_i);
      coll_q <= wr_coll || (coll_q && !collision_clear_i);
      fault_q <= mode_fault || (fault_q && !mode_fault_clear_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Master samples the synchronised input, so the fastest rate
  // leaves little margin against the far end's output delay.
  assign serial_clock_pin_o = sclk_q;
  assign serial_clock_pin_oe_o = is_master;
  assign mosi_o = out_bit;
  assign mosi_oe_o = is_master;
  assign miso_o = out_bit;
  assign miso_oe_o = slave_on;

  assign master_role_bit_o = master_q;
  assign rx_data_o = rx_data_q;
  assign transfer_done_flag_o = done_q;
  assign write_collision_flag_o = coll_q;
  assign holding_full_flag_o = hold_full_q;
  assign mode_fault_flag_o = fault_q;
  assign engine_busy_flag_o = state_q != M_IDLE || active_q ||
                              osr_full_q || hold_full_q;
  assign port_irq_o = irq_enable_i && (done_q || fault_q);

endmodule

// ---- verilog/spi_port_pkg.sv ----
// Shared constants and types of the serial peripheral port
package spi_port_pkg;

  localparam int BYTE_BITS = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic MASTER_RESET = 1'b0;

  // Half serial period in system clocks, per rate code
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV8 = 6'h04;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV32 = 6'h10;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  localparam logic [5:0] HALF_DIV2 = 6'h01;
  // Half period in overflow pulses for the divide-by-six codes
  localparam logic [5:0] HALF_OVF = 6'h03;

  localparam logic [2:0] RATE_UART_OVF = 3'h6;
  localparam logic [2:0] RATE_TIMER_OVF = 3'h7;

  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_SETUP = 3'b010,
    M_SHIFT = 3'b100
  } master_state_type;

endpackage

// ---- verilog/spi_rate_gen.sv ----
// Serial clock rate generator: one tick per half serial period
`timescale 1ns/100ps
module spi_rate_gen
  import spi_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  rate_if.gen rate
);

  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [5:0] half;
  logic ovf_mode;
  logic ovf_pulse;
  logic step;
  logic wrap;

  assign half = (rate.sel == 3'h0) ? HALF_DIV4 :
                (rate.sel == 3'h1) ? HALF_DIV8 :
                (rate.sel == 3'h2) ? HALF_DIV16 :
                (rate.sel == 3'h3) ? HALF_DIV32 :
                (rate.sel == 3'h4) ? HALF_DIV64 :
                (rate.sel == 3'h5) ? HALF_DIV2 : HALF_OVF;
  assign ovf_mode = rate.sel == RATE_UART_OVF || rate.sel == RATE_TIMER_OVF;
  assign ovf_pulse = (rate.sel == RATE_UART_OVF) ? rate.uart_ovf :
                     rate.timer_ovf;
  assign step = ovf_mode ? ovf_pulse : 1'b1;
  assign wrap = step && (cnt_q == half - 6'h01);
  assign cnt_d = !rate.run ? 6'h00 :
                 wrap ? 6'h00 :
                 step ? cnt_q + 6'h01 : cnt_q;
  assign rate.half_tick = rate.run && wrap;

  // Cleared while idle, so every frame opens with a full half period
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule
